// [rtl/sfds_pkg.sv]
// Purpose: Constants and types for the serial flash deep sleep control block.
// Assumes: Core clock of 40 MHz; serial clock is the host's and stands still between frames.
// Notes:   Delays are counted on the core clock.
//
// What this block does
// RULE1 - Deep sleep is entered by one framed entry opcode byte, nothing more.
// RULE2 - While asleep every instruction except the release opcode is ignored.
// RULE3 - Sleep begins only after the entry delay following chip select rising.
// RULE4 - Release acts only if chip select rises right after the eighth bit.
// RULE5 - Release when not asleep returns to standby at once on chip select high.
// RULE6 - Release from sleep reaches standby only after the release delay.
// RULE7 - Release is refused during program or erase, which continues untouched.
// RULE8 - In standby the device awaits selection, then decodes the next instruction.
// RULE9 - After power-up the device is in standby with the write latch cleared.
// RULE10 - Power removal ends deep sleep; no sleep survives a power cycle.
// RULE11 - Host waits the power-up delay before selecting or commanding the device.
// RULE12 - Entry delay from chip select rising to sleep is at most ten microseconds.
// RULE13 - Release delay from chip select rising to standby is at most ten microseconds.
// RULE14 - Ignored instructions drive no output and change no state; output stays released.
package sfds_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] DEEP_SLEEP_ENTRY_CMD   = 8'hb9;
  localparam logic [7:0] DEEP_SLEEP_RELEASE_CMD = 8'hab;
  localparam logic [3:0] BITS_PER_OPCODE        = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ           = 40;
  localparam int SLEEP_ENTRY_DELAY_US   = 10;
  localparam int SLEEP_RELEASE_DELAY_US = 10;
  localparam int DELAY_W                = 9;
  // Longest times round down: the whole-microsecond product already is whole cycles.
  localparam logic [DELAY_W-1:0] ENTRY_CYC   = DELAY_W'(SLEEP_ENTRY_DELAY_US * CLK_FREQ_MHZ);
  localparam logic [DELAY_W-1:0] RELEASE_CYC = DELAY_W'(SLEEP_RELEASE_DELAY_US * CLK_FREQ_MHZ);
  // Chip select crossing and edge detect eat this many cycles of each delay.
  localparam logic [DELAY_W-1:0] SYNC_CYC    = DELAY_W'(3);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_STANDBY, ST_ENTERING, ST_SLEEP, ST_RELEASING} sfds_state_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic       aligned;
  } sfds_frame_s;

endpackage

// [rtl/sfds_sync.sv]
// Purpose: Two flip-flop level synchroniser.
// Assumes: Input changes slowly compared with the destination clock.
// Notes:   The first stage is read by the second stage only.
module sfds_sync
  import sfds_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '1;
      q      <= '1;
    end
    else if (ce)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// [rtl/sfds_ctrl.sv]
// Purpose: Deep sleep entry and release sequencing for a serial flash.
// Assumes: Host keeps the serial clock still while chip select is high.
// Notes:   Rest of the device gates its decoder with instrEnable.
module sfds_ctrl
  import sfds_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic sclk,
  input  wire logic csN,
  input  wire logic si,
  input  wire logic progBusy,
  input  wire logic soOeIn,
  output logic      deepSleep,
  output logic      standby,
  output logic      instrEnable,
  output logic      writeLatchClr,
  output logic      soOe
);

  // ----------------------------------------------------------------
  // Link side, serial clock domain
  // ----------------------------------------------------------------
  logic              frameRst;
  logic [3:0]        bitCnt_q;
  logic [6:0]        shift_q;
  sfds_frame_s       frame_q;

  // Deselect clears the bit count without any serial clock edge.
  assign frameRst = rst | csN;

  always_ff @(posedge sclk or posedge frameRst)
  begin
    if (frameRst)
      bitCnt_q <= 4'h0;
    else if (bitCnt_q != BITS_PER_OPCODE)
      bitCnt_q <= bitCnt_q + 4'h1;
  end

  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
      shift_q <= 7'h00;
    else
      shift_q <= {shift_q[5:0], si};
  end

  // RULE4 exact byte boundary
  // A ninth bit, or the first bit of a later frame, withdraws the mark.
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
      frame_q <= '0;
    else if (bitCnt_q == BITS_PER_OPCODE - 4'h1)
      frame_q <= '{opcode: {shift_q, si}, aligned: 1'b1};
    else
      frame_q.aligned <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Core side, crossing and edge detect
  // ----------------------------------------------------------------
  logic csSync;
  logic csPrev_q;
  logic csRise;
  logic isEntry;
  logic isRelease;

  sfds_sync #(
    .WIDTH (1)
  ) uCsSync (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .d     (csN),
    .q     (csSync)
  );

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      csPrev_q <= 1'b1;
    else if (ce)
      csPrev_q <= csSync;
  end

  // The frame word is read only after deselect has crossed, when the serial
  // clock has stopped, so the whole word is stable without a per-bit crossing.
  assign csRise = csSync & ~csPrev_q;

  // RULE1 single opcode byte
  assign isEntry   = frame_q.aligned & (frame_q.opcode == DEEP_SLEEP_ENTRY_CMD);
  assign isRelease = frame_q.aligned & (frame_q.opcode == DEEP_SLEEP_RELEASE_CMD);

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  sfds_state_e        state_q;
  sfds_state_e        state_d;
  logic [DELAY_W-1:0] delayCnt_q;
  logic               delayDone;

  // The synchroniser latency is taken off the count so the whole delay,
  // measured from chip select rising at the pin, stays within its limit.
  assign delayDone = (state_q == ST_ENTERING) ?
                     (delayCnt_q == ENTRY_CYC - SYNC_CYC - DELAY_W'(1)) :
                     (delayCnt_q == RELEASE_CYC - SYNC_CYC - DELAY_W'(1));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      // RULE8 wait for selection
      ST_STANDBY:
        if (csRise && isEntry)
          state_d = ST_ENTERING;
      // RULE3 wait entry delay
      ST_ENTERING:
        // RULE5 immediate standby
        if (csRise && isRelease && !progBusy)
          state_d = ST_STANDBY;
        else if (delayDone)
          state_d = ST_SLEEP;
      // RULE2 only release acts
      ST_SLEEP:
        // RULE7 busy blocks release
        if (csRise && isRelease && !progBusy)
          state_d = ST_RELEASING;
      // RULE6 wait release delay
      ST_RELEASING:
        if (delayDone)
          state_d = ST_STANDBY;
    endcase
  end

  // RULE10 power loss ends sleep
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_q <= ST_STANDBY;
    else if (ce)
      state_q <= state_d;
  end

  // RULE12 bounded entry count
  // RULE13 bounded release count
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      delayCnt_q <= '0;
    else if (ce)
    begin
      if (state_d != state_q)
        delayCnt_q <= '0;
      else if (state_q == ST_ENTERING || state_q == ST_RELEASING)
        delayCnt_q <= delayCnt_q + DELAY_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // RULE9 standby after power-up
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      deepSleep   <= 1'b0;
      standby     <= 1'b1;
      instrEnable <= 1'b1;
    end
    else if (ce)
    begin
      deepSleep   <= (state_d == ST_SLEEP);
      standby     <= (state_d == ST_STANDBY);
      instrEnable <= (state_d == ST_STANDBY);
    end
  end

  // RULE9 write latch cleared
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      writeLatchClr <= 1'b1;
    else if (ce)
      writeLatchClr <= 1'b0;
  end

  // RULE14 output stays released
  // Gating here keeps the serial output quiet even if the decoder misbehaves.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      soOe <= 1'b0;
    else if (ce)
      soOe <= soOeIn & (state_d == ST_STANDBY);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_sleep_via_entry: assert property ($rose(state_q == ST_SLEEP) // RULE3
                                      |-> $past(state_q) == ST_ENTERING)
    else $error("Sleep reached without entry delay.");
  a_entry_bound: assert property (state_q == ST_ENTERING // RULE12
                                  |-> delayCnt_q < ENTRY_CYC - SYNC_CYC)
    else $error("Entry delay overran.");
  a_release_bound: assert property (state_q == ST_RELEASING // RULE13
                                    |-> delayCnt_q < RELEASE_CYC - SYNC_CYC)
    else $error("Release delay overran.");
  a_sleep_ignores: assert property (state_q == ST_SLEEP && !(csRise && isRelease) // RULE2
                                    |=> state_q == ST_SLEEP)
    else $error("Sleep left without release.");
  a_busy_blocks: assert property (state_q == ST_SLEEP && progBusy |=> state_q == ST_SLEEP) // RULE7
    else $error("Release taken during program cycle.");
  a_no_skip_release: assert property ($past(state_q) == ST_SLEEP |-> state_q != ST_STANDBY) // RULE6
    else $error("Standby without release delay.");
  a_instr_gate: assert property (instrEnable == (state_q == ST_STANDBY) // RULE8
                                 && standby == instrEnable)
    else $error("Instruction enable disagrees with state.");
  a_so_quiet: assert property (!instrEnable |-> !soOe) // RULE14
    else $error("Serial output driven while not in standby.");
  a_release_now: assert property (ce && state_q == ST_ENTERING && csRise && isRelease // RULE5
                                  && !progBusy |=> state_q == ST_STANDBY && standby)
    else $error("Release not immediate when awake.");
  a_misaligned: assert property (ce && state_q == ST_SLEEP && csRise && !frame_q.aligned // RULE4
                                 |=> state_q == ST_SLEEP)
    else $error("Misaligned frame acted on.");

  c_enter: cover property (state_q == ST_ENTERING ##1 state_q == ST_SLEEP);
  c_release: cover property (state_q == ST_RELEASING ##1 state_q == ST_STANDBY);
  c_abort: cover property (state_q == ST_ENTERING ##1 state_q == ST_STANDBY);
  c_busy: cover property (state_q == ST_SLEEP && csRise && isRelease && progBusy);

endmodule

// [test/sfds_host_model.sv]
// Purpose: Host SPI controller model for the deep sleep block.
// Assumes: Mode 0; the serial clock is still and low between frames.
// Notes:   A released data line shows the inverse of its last bit.
module sfds_host_model
(
  output logic sclk,
  output logic csN,
  output logic si
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk = 1'b0;
    csN  = 1'b1;
    si   = 1'b1;
  end

  task automatic sendFrame(input logic [7:0] op, input logic cut, input logic extra);
    int n;
    n = cut ? 7 : (extra ? 9 : 8);
    // The deselect gap leads the frame so the caller can time from chip select rising.
    #100ns;
    csN = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      si = (i < 8) ? op[7-i] : ~op[0];
      #80ns sclk = 1'b1;
      #80ns sclk = 1'b0;
    end
    #80ns csN = 1'b1;
    si = ~si;
  endtask
endmodule

// [test/tb_serial_flash_deep_sleep_control.sv]
// Purpose: Self-checking bench for the deep sleep control block.
// Assumes: Core clock 40 MHz; host serial clock 6.25 MHz, free in phase.
// Notes:   Delay checks allow a few cycles for the chip select synchroniser.
module tb_serial_flash_deep_sleep_control
  import sfds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         SLACK = 6;
  localparam logic [7:0] OTHERS [5] = '{DEEP_SLEEP_ENTRY_CMD, 8'h06, 8'h03, 8'h20, 8'hc7};
  logic clock    = 1'b0;
  logic rst      = 1'b1;
  logic ce       = 1'b1;
  logic progBusy = 1'b0;
  logic soOeIn   = 1'b0;
  logic deepSleep, standby, instrEnable, writeLatchClr, soOe;
  wire  sclk, csN, si;
  int   num_errors  = 0;
  int   checks_done = 0;
  int   cnt;

  always #12.5ns clock = ~clock;

  sfds_host_model host (.sclk(sclk), .csN(csN), .si(si));

  sfds_ctrl dut (.clock(clock), .rst(rst), .ce(ce), .sclk(sclk), .csN(csN), .si(si),
    .progBusy(progBusy), .soOeIn(soOeIn), .deepSleep(deepSleep), .standby(standby),
    .instrEnable(instrEnable), .writeLatchClr(writeLatchClr), .soOe(soOe));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task end_of_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait for sleep or standby; the count is the number of cycles taken.
  task automatic waitHigh(input bit onStandby);
    cnt = 0;
    while ((onStandby ? standby : deepSleep) !== 1'b1)
    begin
      @(negedge clock);
      cnt++;
      if (cnt > 1000)
      begin
        num_errors++;
        end_of_test();
      end
    end
  endtask

  task automatic doReset();
    @(posedge clock) rst <= 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    check("reset sleep", deepSleep, 1'b0);
    check("reset standby", standby, 1'b1);
    check("reset latch clear", writeLatchClr, 1'b1);
    check("reset output", soOe, 1'b0);
    @(posedge clock) rst <= 1'b0;
    repeat (2) @(negedge clock);
    check("latch clear end", writeLatchClr, 1'b0);
    repeat (8) @(posedge clock);
    $display("test reset done");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tEntry();
    @(posedge clock) soOeIn <= 1'b1;
    host.sendFrame(DEEP_SLEEP_ENTRY_CMD, 1'b0, 1'b0);
    waitHigh(1'b0);
    check("entry time", cnt >= ENTRY_CYC - SLACK && cnt <= ENTRY_CYC + 1, 1'b1);
    check("asleep standby", standby, 1'b0);
    check("asleep decode", instrEnable, 1'b0);
    check("asleep output", soOe, 1'b0);
    $display("test entry done");
  endtask

  task automatic tIgnore();
    foreach (OTHERS[i])
      host.sendFrame(OTHERS[i], 1'b0, 1'b0);
    repeat (450) @(negedge clock);
    check("ignored sleep", deepSleep, 1'b1);
    check("ignored output", soOe, 1'b0);
    host.sendFrame(DEEP_SLEEP_RELEASE_CMD, 1'b1, 1'b0);
    host.sendFrame(DEEP_SLEEP_RELEASE_CMD, 1'b0, 1'b1);
    repeat (450) @(negedge clock);
    check("misframed release", deepSleep, 1'b1);
    @(posedge clock) progBusy <= 1'b1;
    host.sendFrame(DEEP_SLEEP_RELEASE_CMD, 1'b0, 1'b0);
    repeat (450) @(negedge clock);
    check("busy release", deepSleep, 1'b1);
    @(posedge clock) progBusy <= 1'b0;
    $display("test ignore done");
  endtask

  task automatic tRelease();
    host.sendFrame(DEEP_SLEEP_RELEASE_CMD, 1'b0, 1'b0);
    waitHigh(1'b1);
    check("release time", cnt >= RELEASE_CYC - SLACK && cnt <= RELEASE_CYC + 1, 1'b1);
    check("awake sleep", deepSleep, 1'b0);
    check("awake decode", instrEnable, 1'b1);
    check("awake output", soOe, 1'b1);
    $display("test release done");
  endtask

  task automatic tCancel();
    host.sendFrame(DEEP_SLEEP_ENTRY_CMD, 1'b0, 1'b0);
    repeat (50) @(negedge clock);
    host.sendFrame(DEEP_SLEEP_RELEASE_CMD, 1'b0, 1'b0);
    repeat (450) @(negedge clock);
    check("cancel sleep", deepSleep, 1'b0);
    check("cancel standby", standby, 1'b1);
    host.sendFrame(DEEP_SLEEP_RELEASE_CMD, 1'b0, 1'b0);
    repeat (6) @(negedge clock);
    check("idle release", standby, 1'b1);
    $display("test cancel done");
  endtask

  task automatic tPower();
    host.sendFrame(DEEP_SLEEP_ENTRY_CMD, 1'b0, 1'b0);
    waitHigh(1'b0);
    doReset();
    check("power cycle sleep", deepSleep, 1'b0);
    $display("test power done");
  endtask

  initial
  begin
    doReset();
    tEntry();
    tIgnore();
    tRelease();
    tCancel();
    tPower();
    end_of_test();
  end
endmodule
